// *** css_chain_model.sv ***
// Behavioural chain of monitoring modules answering measurement commands
`timescale 1ns/100ps
module css_chain_model (
	input  wire logic                                             clk,
	input  wire logic                                             rst_n,
	input  wire logic                                             meas_req,
	input  wire css_pkg::css_req_s                                meas_cmd,
	input  wire logic [2:0]                                       gap,
	input  wire logic [css_pkg::N_CELL-1:0][css_pkg::RATIO_W-1:0] ratios,
	output logic                                                  meas_ack,
	output logic [css_pkg::RATIO_W-1:0]                           meas_ratio
);
	logic [2:0]        cnt_q;
	logic              pend_q;
	css_pkg::css_req_s cmd_q;

	// ----------------------------------------------------------------
	// One answer per command, never in the command's own cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
			pend_q <= 1'b0;
			cmd_q <= '0;
			meas_ack <= 1'b0;
			meas_ratio <= '0;
		end else begin
			meas_ack <= 1'b0;
			// Ratio toggles outside answers so a stale value never looks valid
			meas_ratio <= ~meas_ratio;
			if (meas_req) begin
				pend_q <= 1'b1;
				cmd_q <= meas_cmd;
				cnt_q <= (gap == 3'h0) ? 3'h1 : gap;
			end else if (pend_q) begin
				if (cnt_q <= 3'h1) begin
					meas_ack <= 1'b1;
					pend_q <= 1'b0;
					meas_ratio <= ratios[cmd_q.ch];
				end else begin
					cnt_q <= cnt_q - 3'h1;
				end
			end
		end
	end
endmodule

// *** css_ow_chan.sv ***
// Per-channel open-wire detection counter and fault flag
`timescale 1ns/100ps
module css_ow_chan (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clr,
	input  wire logic                     hit,
	input  wire logic                     dis,
	input  wire logic [css_pkg::CNT_W-1:0] thresh,
	input  wire logic [css_pkg::CNT_W-1:0] max,
	output logic                          flag
);
	logic [css_pkg::CNT_W-1:0] cnt_q;

	// Saturates so a long fault cannot wind the count up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (clr) begin
			cnt_q <= '0;
		end else if (hit && cnt_q < max) begin
			cnt_q <= cnt_q + 8'h01; // R14
		end
	end

	// Count seen during a clear is stale, so it must not hold the flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (!dis && !clr && cnt_q >= thresh && thresh != '0) begin
			flag <= 1'b1; // R13 R11
		end else if (clr) begin
			flag <= 1'b0;
		end
	end

	chk_cnt_saturate: assert property (@(posedge clk) disable iff (!rst_n) // R14
		hit && cnt_q >= max && !clr |=> cnt_q == $past(cnt_q))
		else $error("Detection counter passed its maximum");
	chk_flag_thresh: assert property (@(posedge clk) disable iff (!rst_n) // R13
		$rose(flag) |-> $past(cnt_q) >= $past(thresh) && !$past(dis))
		else $error("Fault flag set below threshold or while disabled");
endmodule

// *** css_pkg.sv ***
// Constants and types shared by the cell scan sequencer files
package css_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS         = 1000;
	localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
	localparam int US_PER_MS     = 1000;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int N_MOD         = 2;
	localparam int CELLS_PER_MOD = 4;
	localparam int N_CELL        = N_MOD * CELLS_PER_MOD;
	localparam int N_THERM       = 8;
	localparam int CH_W          = 3;
	localparam int RATIO_W       = 10;
	localparam int CNT_W         = 8;
	localparam logic [CH_W-1:0] LAST_CELL = CH_W'(N_CELL - 1);
	localparam logic [CH_W-1:0] LAST_MOD  = CH_W'(N_MOD - 1);

	// ----------------------------------------------------------------
	// Register offsets and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_PERIOD  = 8'h04;
	localparam logic [7:0] OFS_SETTLE  = 8'h08;
	localparam logic [7:0] OFS_ACTUAL  = 8'h0C;
	localparam logic [7:0] OFS_OWPER   = 8'h10;
	localparam logic [7:0] OFS_THRESH  = 8'h14;
	localparam logic [7:0] OFS_MAX     = 8'h18;
	localparam logic [7:0] OFS_LOWER   = 8'h1C;
	localparam logic [7:0] OFS_UPPER   = 8'h20;
	localparam logic [7:0] OFS_FAULT   = 8'h24;
	localparam logic [7:0] OFS_STATUS  = 8'h28;
	localparam int CTRL_RUN_BIT        = 0;
	localparam int CTRL_AAF_BIT        = 1;
	localparam int CTRL_OWDIS_BIT      = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  RST_CTRL   = 3'h0;
	localparam logic [31:0] RST_PERIOD = 32'h000003E8;
	localparam logic [31:0] RST_SETTLE = 32'h00000064;
	localparam logic [31:0] RST_OWPER  = 32'hD693A400;
	localparam logic [CNT_W-1:0] RST_THRESH = 8'h03;
	localparam logic [CNT_W-1:0] RST_MAX    = 8'h0A;
	localparam logic [RATIO_W-1:0] RST_LOWER = 10'h320;
	localparam logic [RATIO_W-1:0] RST_UPPER = 10'h3CA;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETTLE = 3'h1,
		ST_CELL   = 3'h2,
		ST_THERM  = 3'h3,
		ST_WAIT   = 3'h4
	} css_state_e;

	typedef enum logic {
		MK_CELL  = 1'b0,
		MK_THERM = 1'b1
	} css_kind_e;

	typedef struct packed {
		css_kind_e       kind;
		logic [CH_W-1:0] ch;
		logic [2:0]      therm;
		logic            ow;
	} css_req_s;

endpackage

// *** css_seq.sv ***
// Cell scan sequencer: scan timing, balancing settle, open-wire diagnostics
//
// Contract
// (R1) Every scan reads the voltage of every cell channel, none skipped.
// (R2) One thermistor per module per scan, rotating through eight.
// (R3) Scan starts are spaced by the programmable scan period.
// (R4) Balancing stops before measuring; never both at once.
// (R5) Balancing stays off for the programmable settle time before measuring.
// (R6) A settle longer than the period stretches the scan.
// (R7) The achieved scan period is measured and readable.
// (R8) One bit selects the anti-alias filter: 0 wide, 1 narrow.
// (R9) Open-wire checks run only outside maintenance inhibit with contactors closed.
// (R10) One fault flag per cell channel.
// (R11) Diagnostic disable bit suppresses all open-wire reporting; code only blocks new flags, set ones hold until a window clears them.
// (R12) Open-wire windows repeat at a programmable interval in microseconds.
// (R13) A flag sets once its detection count reaches the threshold; code never sets a flag while the threshold is zero.
// (R14) Detection counters saturate at the maximum; software keeps it above threshold.
// (R15) An open-wire window lasts as many scans as the maximum count.
// (R16) A ratio below the lower bound counts as a detection.
// (R17) A ratio above the upper bound counts as a detection.
// (R18) Reset clears counters and flags and restarts thermistor rotation.
`timescale 1ns/100ps
module css_seq (
	input  wire logic                           CLOCK,
	input  wire logic                           RST_N,
	input  wire logic [7:0]                     REG_ADDR,
	input  wire logic [31:0]                    REG_WDATA,
	input  wire logic                           REG_WR,
	input  wire logic                           REG_RD,
	output logic [31:0]                         REG_RDATA,
	input  wire logic                           MAINT_INHIBIT,
	input  wire logic                           CONTACTORS_CLOSED,
	output logic                                BAL_ALLOW,
	output logic                                ANTIALIAS_BANDWIDTH_SEL,
	output logic                                MEAS_REQ,
	output css_pkg::css_req_s                   MEAS_CMD,
	input  wire logic                           MEAS_ACK,
	input  wire logic [css_pkg::RATIO_W-1:0]    MEAS_RATIO,
	output logic [css_pkg::N_CELL-1:0]          OW_FAULT
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [2:0]                     ctrl_q;
	logic [31:0]                    period_q;
	logic [31:0]                    settle_q;
	logic [31:0]                    owper_q;
	logic [css_pkg::CNT_W-1:0]      thresh_q;
	logic [css_pkg::CNT_W-1:0]      max_q;
	logic [css_pkg::RATIO_W-1:0]    lower_q;
	logic [css_pkg::RATIO_W-1:0]    upper_q;
	logic [31:0]                    actual_q;
	logic [31:0]                    elapsed_q;
	logic [31:0]                    settle_cnt_q;
	logic [31:0]                    ow_us_q;
	logic                           ow_due_q;
	logic [css_pkg::CNT_W-1:0]      ow_left_q;
	logic                           ow_active_q;
	logic                           ow_clr_q;
	logic [2:0]                     therm_q;
	logic [1:0]                     maint_s;
	logic [1:0]                     cont_s;
	logic                           diag_ok_q;
	logic                           us_tick;
	logic                           ms_tick;
	logic                           scan_start;
	logic                           scan_done;
	logic                           owdis;
	css_pkg::css_state_e            state_q;

	assign owdis      = ctrl_q[css_pkg::CTRL_OWDIS_BIT];
	assign scan_start = (state_q == css_pkg::ST_IDLE && ctrl_q[css_pkg::CTRL_RUN_BIT])
		|| (state_q == css_pkg::ST_WAIT && ctrl_q[css_pkg::CTRL_RUN_BIT]
		&& elapsed_q >= period_q);
	assign scan_done  = state_q == css_pkg::ST_THERM && MEAS_ACK
		&& MEAS_CMD.ch == css_pkg::LAST_MOD;
	assign ANTIALIAS_BANDWIDTH_SEL = ctrl_q[css_pkg::CTRL_AAF_BIT]; // R8

	function automatic logic ratio_bad(input logic [css_pkg::RATIO_W-1:0] r,
		input logic [css_pkg::RATIO_W-1:0] lo, input logic [css_pkg::RATIO_W-1:0] hi);
		ratio_bad = (r < lo) || (r > hi);
	endfunction

	function automatic logic [css_pkg::CH_W-1:0] ch_idx(input int n);
		ch_idx = n[css_pkg::CH_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	css_tick_div u_tick (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.us_tick (us_tick),
		.ms_tick (ms_tick)
	);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			maint_s   <= 2'h3;
			cont_s    <= 2'h0;
			diag_ok_q <= 1'b0;
		end else begin
			maint_s   <= {maint_s[0], MAINT_INHIBIT};
			cont_s    <= {cont_s[0], CONTACTORS_CLOSED};
			diag_ok_q <= !maint_s[1] && cont_s[1]; // R9
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q   <= css_pkg::RST_CTRL;
			period_q <= css_pkg::RST_PERIOD;
			settle_q <= css_pkg::RST_SETTLE;
			owper_q  <= css_pkg::RST_OWPER;
			thresh_q <= css_pkg::RST_THRESH;
			max_q    <= css_pkg::RST_MAX;
			lower_q  <= css_pkg::RST_LOWER;
			upper_q  <= css_pkg::RST_UPPER;
		end else if (REG_WR) begin
			case (REG_ADDR)
				css_pkg::OFS_CTRL:   ctrl_q   <= REG_WDATA[2:0];
				css_pkg::OFS_PERIOD: period_q <= REG_WDATA; // R3
				css_pkg::OFS_SETTLE: settle_q <= REG_WDATA; // R5
				css_pkg::OFS_OWPER:  owper_q  <= REG_WDATA; // R12
				css_pkg::OFS_THRESH: thresh_q <= REG_WDATA[css_pkg::CNT_W-1:0];
				css_pkg::OFS_MAX:    max_q    <= REG_WDATA[css_pkg::CNT_W-1:0];
				css_pkg::OFS_LOWER:  lower_q  <= REG_WDATA[css_pkg::RATIO_W-1:0];
				css_pkg::OFS_UPPER:  upper_q  <= REG_WDATA[css_pkg::RATIO_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				css_pkg::OFS_CTRL:   REG_RDATA <= {29'h0, ctrl_q};
				css_pkg::OFS_PERIOD: REG_RDATA <= period_q;
				css_pkg::OFS_SETTLE: REG_RDATA <= settle_q;
				css_pkg::OFS_ACTUAL: REG_RDATA <= actual_q; // R7
				css_pkg::OFS_OWPER:  REG_RDATA <= owper_q;
				css_pkg::OFS_THRESH: REG_RDATA <= {24'h0, thresh_q};
				css_pkg::OFS_MAX:    REG_RDATA <= {24'h0, max_q};
				css_pkg::OFS_LOWER:  REG_RDATA <= {22'h0, lower_q};
				css_pkg::OFS_UPPER:  REG_RDATA <= {22'h0, upper_q};
				css_pkg::OFS_FAULT:  REG_RDATA <= {24'h0, OW_FAULT}; // R10
				css_pkg::OFS_STATUS: REG_RDATA <= {8'h0, ow_left_q, 7'h0, diag_ok_q,
					BAL_ALLOW, therm_q, 1'b0, state_q};
				default:             REG_RDATA <= 32'h00000000;
			endcase
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Scan period measurement
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			elapsed_q <= 32'h00000000;
			actual_q  <= 32'h00000000;
		end else if (scan_start) begin
			elapsed_q <= 32'h00000000;
			if (state_q == css_pkg::ST_WAIT) begin
				actual_q <= elapsed_q; // R7
			end
		end else if (ms_tick) begin
			elapsed_q <= elapsed_q + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// Scan state machine
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q      <= css_pkg::ST_IDLE;
			settle_cnt_q <= 32'h00000000;
			MEAS_REQ     <= 1'b0;
			MEAS_CMD     <= '0;
			BAL_ALLOW    <= 1'b1;
		end else begin
			MEAS_REQ <= 1'b0;
			case (state_q)
				css_pkg::ST_IDLE, css_pkg::ST_WAIT: begin
					if (scan_start) begin
						state_q      <= css_pkg::ST_SETTLE;
						settle_cnt_q <= 32'h00000000;
						BAL_ALLOW    <= 1'b0; // R4
					end else if (!ctrl_q[css_pkg::CTRL_RUN_BIT]) begin
						state_q <= css_pkg::ST_IDLE;
					end
				end
				css_pkg::ST_SETTLE: begin
					// Scan waits here even past the period, stretching it
					if (settle_cnt_q >= settle_q) begin // R5 R6
						state_q       <= css_pkg::ST_CELL;
						MEAS_REQ      <= 1'b1;
						MEAS_CMD.kind <= css_pkg::MK_CELL;
						MEAS_CMD.ch   <= '0;
						MEAS_CMD.ow   <= ow_active_q && diag_ok_q; // R9
					end else if (ms_tick) begin
						settle_cnt_q <= settle_cnt_q + 32'h00000001;
					end
				end
				css_pkg::ST_CELL: begin
					if (MEAS_ACK) begin
						MEAS_REQ <= 1'b1;
						if (MEAS_CMD.ch == css_pkg::LAST_CELL) begin // R1
							state_q        <= css_pkg::ST_THERM;
							MEAS_CMD.kind  <= css_pkg::MK_THERM;
							MEAS_CMD.ch    <= '0;
							MEAS_CMD.therm <= therm_q; // R2
							MEAS_CMD.ow    <= 1'b0;
						end else begin
							MEAS_CMD.ch <= MEAS_CMD.ch + 3'h1; // R1
							MEAS_CMD.ow <= MEAS_CMD.ow && diag_ok_q; // R9
						end
					end
				end
				css_pkg::ST_THERM: begin
					if (scan_done) begin
						state_q   <= css_pkg::ST_WAIT;
						BAL_ALLOW <= 1'b1;
					end else if (MEAS_ACK) begin
						MEAS_REQ    <= 1'b1;
						MEAS_CMD.ch <= MEAS_CMD.ch + 3'h1; // R2
					end
				end
				default: begin
					state_q   <= css_pkg::ST_IDLE;
					BAL_ALLOW <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Thermistor rotation
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			therm_q <= 3'h0; // R18
		end else if (scan_done) begin
			therm_q <= therm_q + 3'h1; // R2
		end
	end

	// ----------------------------------------------------------------
	// Open-wire scheduling
	// ----------------------------------------------------------------
	// Interval timer only runs while diagnostics are permitted
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ow_us_q  <= 32'h00000000;
			ow_due_q <= 1'b0;
		end else begin
			// Clear first so an expiry in the same cycle is kept
			if (ow_clr_q) begin
				ow_due_q <= 1'b0;
			end
			if (us_tick && diag_ok_q) begin
				if (ow_us_q >= owper_q - 32'h00000001) begin
					ow_us_q  <= 32'h00000000;
					ow_due_q <= 1'b1; // R12
				end else begin
					ow_us_q <= ow_us_q + 32'h00000001;
				end
			end
		end
	end

	// Window spans max_q scans so each channel gets max_q samples
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ow_left_q   <= '0;
			ow_active_q <= 1'b0;
			ow_clr_q    <= 1'b0;
		end else begin
			ow_clr_q <= 1'b0;
			if (scan_start) begin
				if (ow_left_q == '0 && ow_due_q && diag_ok_q && max_q != '0) begin
					ow_left_q   <= max_q; // R15
					ow_active_q <= 1'b1;
					ow_clr_q    <= 1'b1;
				end else begin
					ow_active_q <= ow_left_q != '0 && diag_ok_q; // R9
				end
			end else if (scan_done && ow_active_q) begin
				ow_left_q   <= ow_left_q - 8'h01; // R15
				ow_active_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-channel detection
	// ----------------------------------------------------------------
	for (genvar i = 0; i < css_pkg::N_CELL; i++) begin : g_ch
		logic hit;
		assign hit = MEAS_ACK && MEAS_CMD.ow && MEAS_CMD.kind == css_pkg::MK_CELL
			&& MEAS_CMD.ch == ch_idx(i)
			&& ratio_bad(MEAS_RATIO, lower_q, upper_q); // R16 R17
		css_ow_chan u_ow (
			.clk    (CLOCK),
			.rst_n  (RST_N),
			.clr    (ow_clr_q),
			.hit    (hit),
			.dis    (owdis),
			.thresh (thresh_q),
			.max    (max_q),
			.flag   (OW_FAULT[i])
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_bal_meas_excl: assert property (@(posedge CLOCK) disable iff (!RST_N) // R4
		MEAS_REQ |-> !BAL_ALLOW)
		else $error("Measurement requested while balancing allowed");
	chk_settle_time: assert property (@(posedge CLOCK) disable iff (!RST_N) // R5
		state_q == css_pkg::ST_CELL && $past(state_q) == css_pkg::ST_SETTLE
		|-> $past(settle_cnt_q) >= $past(settle_q) && !BAL_ALLOW)
		else $error("Measurement began before settle time");
	chk_all_cells: assert property (@(posedge CLOCK) disable iff (!RST_N) // R1
		state_q == css_pkg::ST_THERM && $past(state_q) == css_pkg::ST_CELL
		|-> $past(MEAS_CMD.ch) == css_pkg::LAST_CELL && $past(MEAS_ACK))
		else $error("Cell phase ended before last channel");
	chk_therm_rotate: assert property (@(posedge CLOCK) disable iff (!RST_N) // R2
		scan_done |=> therm_q == $past(therm_q) + 3'h1)
		else $error("Thermistor rotation did not advance");
	chk_period_wait: assert property (@(posedge CLOCK) disable iff (!RST_N) // R3
		state_q == css_pkg::ST_WAIT ##1 state_q == css_pkg::ST_SETTLE
		|-> $past(elapsed_q) >= $past(period_q))
		else $error("Scan started before period elapsed");
	chk_actual_capture: assert property (@(posedge CLOCK) disable iff (!RST_N) // R7
		scan_start && state_q == css_pkg::ST_WAIT
		|=> actual_q == $past(elapsed_q) && elapsed_q == 32'h00000000)
		else $error("Achieved period not captured");
	chk_filter_sel: assert property (@(posedge CLOCK) disable iff (!RST_N) // R8
		REG_WR && REG_ADDR == css_pkg::OFS_CTRL
		|=> ANTIALIAS_BANDWIDTH_SEL == $past(REG_WDATA[css_pkg::CTRL_AAF_BIT]))
		else $error("Filter select does not follow control write");
	chk_ow_gate: assert property (@(posedge CLOCK) disable iff (!RST_N) // R9
		MEAS_REQ && MEAS_CMD.ow |-> $past(diag_ok_q))
		else $error("Open-wire sample taken while diagnostics barred");
	chk_ow_disable: assert property (@(posedge CLOCK) disable iff (!RST_N) // R11
		owdis && $past(owdis) |-> !$rose(OW_FAULT[0]))
		else $error("Fault flag rose while reporting disabled");
endmodule

// *** css_seq_bench.sv ***
// Self-checking bench for the cell scan sequencer
`timescale 1ns/100ps
module css_seq_bench;
	logic                                             clock;
	logic                                             rst_n;
	logic [7:0]                                       reg_addr;
	logic [31:0]                                      reg_wdata;
	logic                                             reg_wr;
	logic                                             reg_rd;
	logic [31:0]                                      reg_rdata;
	logic                                             maint;
	logic                                             closed;
	logic                                             bal_allow;
	logic                                             aaf;
	logic                                             meas_req;
	css_pkg::css_req_s                                cmd;
	logic                                             meas_ack;
	logic [css_pkg::RATIO_W-1:0]                      ratio;
	logic [css_pkg::N_CELL-1:0]                       ow_fault;
	logic [2:0]                                       gap;
	logic [css_pkg::N_CELL-1:0][css_pkg::RATIO_W-1:0] ratios;
	logic [31:0]                                      seed;
	logic [31:0]                                      d;
	int n_errors, comparisons, pos, scan, n_ow0, win, windows, n_owreq, seen, i;

	css_seq uut (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MAINT_INHIBIT(maint),
		.CONTACTORS_CLOSED(closed), .BAL_ALLOW(bal_allow), .ANTIALIAS_BANDWIDTH_SEL(aaf),
		.MEAS_REQ(meas_req), .MEAS_CMD(cmd), .MEAS_ACK(meas_ack), .MEAS_RATIO(ratio),
		.OW_FAULT(ow_fault));
	css_chain_model chain (.clk(clock), .rst_n(rst_n), .meas_req(meas_req), .meas_cmd(cmd),
		.gap(gap), .ratios(ratios), .meas_ack(meas_ack), .meas_ratio(ratio));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_fault();
		logic [31:0] f;
		f = 32'h0;
		for (int c = 0; c < css_pkg::N_CELL; c++) begin
			f[c] = ratios[c] < css_pkg::RST_LOWER || ratios[c] > css_pkg::RST_UPPER;
		end
		return f;
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, random answer delay, watchdog
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		seed <= lfsr(seed);
		gap <= seed[2:0];
	end
	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Command monitor: order, rotation, windows
	// ----------------------------------------------------------------
	always @(negedge clock) begin
		if (meas_req === 1'b1) begin
			if (pos < 8) begin
				chk("cell channel", pos, {cmd.kind, cmd.ch});
				chk("balancing during measure", 0, bal_allow);
				if (cmd.ow === 1'b1) n_owreq++;
				if (pos == 0 && cmd.ow === 1'b1) begin
					n_ow0++;
					win++;
				end else if (pos == 0 && win != 0) begin
					chk("window scans", 4, win);
					windows++;
					win = 0;
				end
			end else begin
				chk("therm module", 8'h10 | (pos - 8), {cmd.kind, 1'b0, cmd.ch});
				chk("therm index", scan % css_pkg::N_THERM, cmd.therm);
			end
			pos = (pos == 9) ? 0 : pos + 1;
			if (pos == 0) scan++;
		end
		if (ow_fault[0] === 1'b1 && seen == 0) begin
			seen = 1;
			chk("hits at flag", 3, n_ow0);
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{n_errors, comparisons, pos, scan, n_ow0, win, windows, n_owreq, seen} = '0;
		maint = 1'b0;
		closed = 1'b0;
		rst_n = 1'b0;
		seed = 32'he923fbf3;
		gap = 3'h1;
		// Boundary ratios one step past each bound, exact bounds, then random
		ratios[0] = 10'd799;
		ratios[1] = 10'd971;
		ratios[2] = 10'd800;
		ratios[3] = 10'd970;
		for (i = 4; i < css_pkg::N_CELL; i++) begin
			seed = lfsr(seed);
			ratios[i] = 10'(801 + seed % 169);
		end
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk("fault after reset", 0, ow_fault);
		rd(8'h04, d); chk("period reset", css_pkg::RST_PERIOD, d);
		rd(8'h08, d); chk("settle reset", css_pkg::RST_SETTLE, d);
		rd(8'h10, d); chk("owper reset", css_pkg::RST_OWPER, d);
		rd(8'h14, d); chk("thresh reset", css_pkg::RST_THRESH, d);
		rd(8'h18, d); chk("max reset", css_pkg::RST_MAX, d);
		rd(8'h1C, d); chk("lower reset", css_pkg::RST_LOWER, d);
		rd(8'h20, d); chk("upper reset", css_pkg::RST_UPPER, d);
		wr(8'h2C, 32'hFFFF); rd(8'h2C, d); chk("unmapped", 0, d);
		for (i = 1; i >= 0; i--) begin
			wr(8'h00, 32'(i << 1)); @(negedge clock); chk("filter select", i, aaf);
		end
		$display("test registers done");
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h10, 32'd50);
		wr(8'h18, 32'h4);
		wr(8'h00, 32'h1);
		repeat (6000) @(posedge clock);
		chk("ow with contactors open", 0, n_owreq);
		rd(8'h0C, d); chk("actual period", 0, d);
		@(posedge clock);
		closed <= 1'b1;
		for (i = 0; i < 20000 && ow_fault !== exp_fault(); i++) @(posedge clock);
		chk("fault flags", exp_fault(), ow_fault);
		wr(8'h24, 32'h0); rd(8'h24, d); chk("fault reg", exp_fault(), d);
		$display("test detection done");
		wr(8'h00, 32'h5);
		for (i = 0; i < 20000 && windows < 2; i++) @(posedge clock);
		chk("second window", 2, windows);
		chk("flags with disable", 0, ow_fault);
		$display("test disable done");
		maint <= 1'b1;
		repeat (20) @(posedge clock);
		n_owreq = 0;
		repeat (7000) @(posedge clock);
		chk("ow under inhibit", 0, n_owreq);
		chk("scans ran", 1, scan > 20);
		$display("test inhibit done");
		summarize();
	end
endmodule

// *** css_tick_div.sv ***
// Microsecond and millisecond enable pulses from the system clock
`timescale 1ns/100ps
module css_tick_div (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      us_tick,
	output logic      ms_tick
);
	logic [7:0] cyc_q;
	logic [9:0] us_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q   <= 8'h00;
			us_tick <= 1'b0;
		end else if (cyc_q == 8'(css_pkg::US_CYC - 1)) begin
			cyc_q   <= 8'h00;
			us_tick <= 1'b1;
		end else begin
			cyc_q   <= cyc_q + 8'h01;
			us_tick <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			us_q    <= 10'h000;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= 1'b0;
			if (us_tick) begin
				if (us_q == 10'(css_pkg::US_PER_MS - 1)) begin
					us_q    <= 10'h000;
					ms_tick <= 1'b1;
				end else begin
					us_q <= us_q + 10'h001;
				end
			end
		end
	end
endmodule
